// ===== logic/cmd_decoder.sv
`timescale 1ns/1ps
// Behaviour
// - 0x001 writes, 0x002 reads setup group
// - 0x004..0x00A read cell groups A-D
// - 0x00C, 0x00E read aux groups A, B
// - 0x010, 0x012 read system groups A, B
// - cell conversion encoding and its fields
// - open-wire conversion encoding and its fields
// - cell self-test encoding, pattern and rate
// - aux conversion encoding, selection and rate
// - aux self-test encoding, pattern and rate
// - system conversion encoding, selection and rate
// - system self-test encoding, pattern and rate
// - combined cells plus aux12 conversion encoding
// - 0x711-0x713 clear cell, aux, system groups
// - 0x714 reports conversion still in progress
// - 0x715 runs mux check, reports busy
// - 0x721 writes, 0x722 reads link group
// - rate field maps per alternate-rate option
// - balance bit permits discharge during conversion
// - cell selection: all or pair n, n+6
// - cell-pair conversion times per rate
// - direction bit: 0 pull-down, 1 pull-up
// - broadcast or matching address accepted
// - aux selection: all, input n, reference
// - system selection 5, 6 acts as aux
// - fixed self-test results per pattern, rate
module cmd_decoder #(
  parameter logic [5:0][27:0] ALL_CYC = cmd_pkg::ALL_CYC_DEF,
  parameter logic [5:0][27:0] PAIR_CYC = cmd_pkg::PAIR_CYC_DEF,
  parameter logic [5:0][27:0] SYS_ALL_CYC = cmd_pkg::SYS_ALL_CYC_DEF
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire cmd_pkg::cmd_frame_t cmd_frame,
  input wire logic alt_rate_opt,
  input wire logic [3:0] device_addr,
  output cmd_pkg::cmd_kind_t dec_kind,
  output logic dec_valid,
  output logic dec_ignored,
  output cmd_pkg::cmd_opts_t opts,
  output logic conv_busy,
  output logic poll_valid,
  output logic poll_busy
);
  logic [10:0] cc;
  logic [2:0] sel;
  logic [1:0] md;
  logic [1:0] pat;
  logic is_broadcast;
  logic is_addressed;
  logic for_me;
  logic grp01;
  logic grp10;
  logic sel_all;
  logic sel_max;
  logic hit_cells;
  logic hit_open;
  logic hit_cell_st;
  logic hit_aux;
  logic hit_aux_st;
  logic hit_sys;
  logic hit_sys_as_aux;
  logic hit_sys_st;
  logic hit_cvax;
  logic [2:0] rate;
  cmd_pkg::cmd_kind_t kind;
  logic known;
  logic starts_conv;
  logic reports;
  logic [27:0] cyc_all;
  logic [27:0] cyc_pair;
  logic [27:0] cyc_sel;
  logic [15:0] st_result;
  cmd_pkg::cmd_opts_t next_opts;
  cmd_pkg::cmd_state_t state;
  cmd_pkg::cmd_state_t next_state;
  logic [27:0] cnt;
  logic [27:0] next_cnt;
  logic take;

  assign cc = {cmd_frame.opcode_high_byte[2:0], cmd_frame.low_byte};
  assign sel = cc[cmd_pkg::F_SEL_HI:cmd_pkg::F_SEL_LO];
  assign md = cc[cmd_pkg::F_RATE_HI:cmd_pkg::F_RATE_LO];
  assign pat = cc[cmd_pkg::F_PAT_HI:cmd_pkg::F_PAT_LO];

  assign is_broadcast = cmd_frame.opcode_high_byte[7:3] == 5'h00;
  assign is_addressed = cmd_frame.opcode_high_byte[cmd_pkg::F_ADDR_FLAG] &&
    (cmd_frame.opcode_high_byte[cmd_pkg::F_ADDR_HI:cmd_pkg::F_ADDR_LO] == device_addr);
  assign for_me = cmd_valid && (is_broadcast || is_addressed);

  assign grp01 = cc[cmd_pkg::F_GRP_HI:cmd_pkg::F_GRP_LO] == 2'h1;
  assign grp10 = cc[cmd_pkg::F_GRP_HI:cmd_pkg::F_GRP_LO] == 2'h2;
  assign sel_all = sel == 3'h0;
  assign sel_max = sel == 3'h7;

  // selection 111 is no valid channel, so it is left to the self-test forms and the cells plus aux12 form
  assign hit_cell_st = grp01 && cc[4:3] == 2'h0 && sel_max;
  assign hit_cells = grp01 && pat == 2'h3 && !cc[cmd_pkg::F_B3] && !sel_max;
  assign hit_open = grp01 && cc[cmd_pkg::F_OW] && cc[cmd_pkg::F_B3] && !sel_max;
  assign hit_aux_st = grp10 && cc[4:3] == 2'h0 && sel_max;
  assign hit_aux = grp10 && pat == 2'h3 && cc[4:3] == 2'h0 && !sel_max;
  assign hit_cvax = grp10 && pat == 2'h3 && cc[3:0] == 4'hF;
  assign hit_sys_st = grp10 && !cc[cmd_pkg::F_BAL] && cc[cmd_pkg::F_B3] && sel_max &&
    !hit_cvax;
  assign hit_sys = grp10 && pat == 2'h3 && !cc[cmd_pkg::F_BAL] && cc[cmd_pkg::F_B3] &&
    sel < 3'h5;
  assign hit_sys_as_aux = grp10 && pat == 2'h3 && !cc[cmd_pkg::F_BAL] && cc[cmd_pkg::F_B3] &&
    (sel == 3'h5 || sel == 3'h6);

  assign kind =
    (cc == cmd_pkg::OP_WRITE_SETUP_GROUP) ? cmd_pkg::K_WRITE_SETUP_GROUP :
    (cc == cmd_pkg::OP_READ_SETUP_GROUP) ? cmd_pkg::K_READ_SETUP_GROUP :
    (cc == cmd_pkg::OP_READ_CELL_GROUP_A) ? cmd_pkg::K_READ_CELL_GROUP_A :
    (cc == cmd_pkg::OP_READ_CELL_GROUP_B) ? cmd_pkg::K_READ_CELL_GROUP_B :
    (cc == cmd_pkg::OP_READ_CELL_GROUP_C) ? cmd_pkg::K_READ_CELL_GROUP_C :
    (cc == cmd_pkg::OP_READ_CELL_GROUP_D) ? cmd_pkg::K_READ_CELL_GROUP_D :
    (cc == cmd_pkg::OP_READ_AUX_GROUP_A) ? cmd_pkg::K_READ_AUX_GROUP_A :
    (cc == cmd_pkg::OP_READ_AUX_GROUP_B) ? cmd_pkg::K_READ_AUX_GROUP_B :
    (cc == cmd_pkg::OP_READ_SYS_GROUP_A) ? cmd_pkg::K_READ_SYS_GROUP_A :
    (cc == cmd_pkg::OP_READ_SYS_GROUP_B) ? cmd_pkg::K_READ_SYS_GROUP_B :
    (cc == cmd_pkg::OP_CLEAR_CELL_GROUP) ? cmd_pkg::K_CLEAR_CELL_GROUP :
    (cc == cmd_pkg::OP_CLEAR_AUX_GROUP) ? cmd_pkg::K_CLEAR_AUX_GROUP :
    (cc == cmd_pkg::OP_CLEAR_SYS_GROUP) ? cmd_pkg::K_CLEAR_SYS_GROUP :
    (cc == cmd_pkg::OP_POLL_CONVERSION) ? cmd_pkg::K_POLL_CONVERSION :
    (cc == cmd_pkg::OP_CHECK_MUX) ? cmd_pkg::K_CHECK_MUX :
    (cc == cmd_pkg::OP_WRITE_LINK_GROUP) ? cmd_pkg::K_WRITE_LINK_GROUP :
    (cc == cmd_pkg::OP_READ_LINK_GROUP) ? cmd_pkg::K_READ_LINK_GROUP :
    hit_cell_st ? cmd_pkg::K_CHECK_CELLS_SELFTEST :
    hit_cells ? cmd_pkg::K_CONVERT_CELLS :
    hit_open ? cmd_pkg::K_CONVERT_OPEN_WIRE :
    hit_cvax ? cmd_pkg::K_CONVERT_CELLS_AUX12 :
    hit_aux_st ? cmd_pkg::K_CHECK_AUX_SELFTEST :
    (hit_aux || hit_sys_as_aux) ? cmd_pkg::K_CONVERT_AUX :
    hit_sys_st ? cmd_pkg::K_CHECK_SYS_SELFTEST :
    hit_sys ? cmd_pkg::K_CONVERT_SYS :
    cmd_pkg::K_NONE;

  assign known = kind != cmd_pkg::K_NONE;
  assign starts_conv = kind inside {cmd_pkg::K_CONVERT_CELLS, cmd_pkg::K_CONVERT_OPEN_WIRE,
    cmd_pkg::K_CHECK_CELLS_SELFTEST, cmd_pkg::K_CONVERT_AUX, cmd_pkg::K_CHECK_AUX_SELFTEST,
    cmd_pkg::K_CONVERT_SYS, cmd_pkg::K_CHECK_SYS_SELFTEST, cmd_pkg::K_CONVERT_CELLS_AUX12,
    cmd_pkg::K_CHECK_MUX};
  assign reports = kind == cmd_pkg::K_POLL_CONVERSION || kind == cmd_pkg::K_CHECK_MUX;
  assign take = for_me && known;

  // rate code 00 is not defined; it is taken as the fastest pair
  assign rate = (md == 2'h2) ? (alt_rate_opt ? cmd_pkg::RATE_3K : cmd_pkg::RATE_7K) :
    (md == 2'h3) ? (alt_rate_opt ? cmd_pkg::RATE_2K : cmd_pkg::RATE_26HZ) :
    (alt_rate_opt ? cmd_pkg::RATE_14K : cmd_pkg::RATE_27K);

  assign cyc_all = ALL_CYC[rate];
  assign cyc_pair = PAIR_CYC[rate];
  assign cyc_sel =
    (kind == cmd_pkg::K_CHECK_MUX) ? PAIR_CYC[cmd_pkg::RATE_27K] :
    (kind == cmd_pkg::K_CONVERT_SYS) ? (sel_all ? SYS_ALL_CYC[rate] : cyc_pair) :
    (kind inside {cmd_pkg::K_CONVERT_CELLS, cmd_pkg::K_CONVERT_OPEN_WIRE,
      cmd_pkg::K_CONVERT_AUX}) ? (sel_all ? cyc_all : cyc_pair) :
    cyc_all;

  assign st_result =
    (pat == 2'h1) ? ((rate == cmd_pkg::RATE_27K) ? cmd_pkg::ST1_FAST :
      (rate == cmd_pkg::RATE_14K) ? cmd_pkg::ST1_MID : cmd_pkg::ST1_SLOW) :
    (pat == 2'h2) ? ((rate == cmd_pkg::RATE_27K) ? cmd_pkg::ST2_FAST :
      (rate == cmd_pkg::RATE_14K) ? cmd_pkg::ST2_MID : cmd_pkg::ST2_SLOW) :
    16'h0000;

  always_comb begin
    next_opts = opts;
    if (take && kind != cmd_pkg::K_POLL_CONVERSION && starts_conv) begin
      next_opts = cmd_pkg::OPTS_RST;
      next_opts.adc_rate_sel = rate;
      next_opts.conv_cycles = cyc_sel;
      if (kind inside {cmd_pkg::K_CONVERT_CELLS, cmd_pkg::K_CONVERT_OPEN_WIRE,
          cmd_pkg::K_CONVERT_CELLS_AUX12}) begin
        next_opts.balance_allow = cc[cmd_pkg::F_BAL];
      end
      if (kind == cmd_pkg::K_CONVERT_OPEN_WIRE) begin
        next_opts.wire_test_current_dir = cc[cmd_pkg::F_DIR];
      end
      if (kind == cmd_pkg::K_CONVERT_CELLS || kind == cmd_pkg::K_CONVERT_OPEN_WIRE) begin
        if (sel_all) begin
          next_opts.cell_mask = 12'hFFF;
        end else begin
          next_opts.cell_mask = 12'(12'h041 << (sel - 3'h1));
        end
      end
      if (kind == cmd_pkg::K_CONVERT_CELLS_AUX12) begin
        next_opts.cell_mask = 12'hFFF;
        next_opts.aux_mask = 6'h03;
      end
      if (kind == cmd_pkg::K_CONVERT_AUX) begin
        if (sel_all) begin
          next_opts.aux_mask = 6'h3F;
        end else begin
          next_opts.aux_mask = 6'(6'h01 << (sel - 3'h1));
        end
      end
      if (kind == cmd_pkg::K_CONVERT_SYS) begin
        next_opts.sys_group_sel = sel;
      end
      if (kind inside {cmd_pkg::K_CHECK_CELLS_SELFTEST, cmd_pkg::K_CHECK_AUX_SELFTEST,
          cmd_pkg::K_CHECK_SYS_SELFTEST}) begin
        next_opts.diag_pattern_sel = pat;
        next_opts.diag_result = st_result;
      end
    end
  end

  // a new conversion while busy restarts the timer with the new length
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      cmd_pkg::ST_IDLE: begin
        next_cnt = cmd_pkg::CNT_RST;
      end
      cmd_pkg::ST_BUSY: begin
        if (cnt == cmd_pkg::CNT_RST) begin
          next_state = cmd_pkg::ST_IDLE;
        end else begin
          next_cnt = cnt - 28'h0000001;
        end
      end
      default: begin
        next_state = cmd_pkg::ST_IDLE;
        next_cnt = cmd_pkg::CNT_RST;
      end
    endcase
    if (take && starts_conv) begin
      next_state = cmd_pkg::ST_BUSY;
      next_cnt = cyc_sel - 28'h0000001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= cmd_pkg::ST_IDLE;
      cnt <= cmd_pkg::CNT_RST;
      opts <= cmd_pkg::OPTS_RST;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      opts <= next_opts;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dec_kind <= cmd_pkg::K_NONE;
      dec_valid <= 1'b0;
      dec_ignored <= 1'b0;
      conv_busy <= 1'b0;
      poll_valid <= 1'b0;
      poll_busy <= 1'b0;
    end else begin
      dec_kind <= take ? kind : dec_kind;
      dec_valid <= take;
      dec_ignored <= cmd_valid && !take;
      conv_busy <= next_state == cmd_pkg::ST_BUSY;
      poll_valid <= take && reports;
      poll_busy <= (take && reports) ? (next_state == cmd_pkg::ST_BUSY) : poll_busy;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  setup_write_a: assert property (
    take && cc == cmd_pkg::OP_WRITE_SETUP_GROUP |=>
    dec_valid && dec_kind == cmd_pkg::K_WRITE_SETUP_GROUP) else $error("setup write");
  cell_read_a: assert property (
    for_me && cc == 11'h00A |=> dec_kind == cmd_pkg::K_READ_CELL_GROUP_D)
    else $error("cell group d read");
  clear_sys_a: assert property (
    for_me && cc == 11'h713 |=>
    dec_kind == cmd_pkg::K_CLEAR_SYS_GROUP && (!conv_busy || $past(conv_busy)))
    else $error("clear system group");
  cells_conv_a: assert property (
    for_me && cc == 11'h2E0 |=>
    dec_kind == cmd_pkg::K_CONVERT_CELLS && conv_busy && opts.cell_mask == 12'hFFF)
    else $error("cell conversion");
  pair_mask_a: assert property (
    for_me && cc == 11'h373 |=>
    opts.cell_mask == 12'h104 && opts.adc_rate_sel == ($past(alt_rate_opt) ? 3'h3 : 3'h2))
    else $error("cell pair mask");
  open_dir_a: assert property (
    for_me && cc[10:9] == 2'h1 && cc[5] && cc[3] && cc[2:0] != 3'h7 |=>
    dec_kind == cmd_pkg::K_CONVERT_OPEN_WIRE &&
    opts.wire_test_current_dir == $past(cc[6]) && opts.balance_allow == $past(cc[4]))
    else $error("open wire fields");
  sys_alias_a: assert property (
    for_me && cc == 11'h4ED |=>
    dec_kind == cmd_pkg::K_CONVERT_AUX && opts.aux_mask == 6'h10)
    else $error("system selection alias");
  selftest_a: assert property (
    for_me && cc == 11'h2A7 && !alt_rate_opt |=>
    dec_kind == cmd_pkg::K_CHECK_CELLS_SELFTEST && opts.diag_result == 16'h9565)
    else $error("self-test result");
  fast_pair_time_a: assert property (
    for_me && cc == 11'h2E1 && !alt_rate_opt |=>
    conv_busy [*8] ##0 opts.conv_cycles == PAIR_CYC[cmd_pkg::RATE_27K])
    else $error("pair time");
  unknown_a: assert property (
    cmd_valid && kind == cmd_pkg::K_NONE |=>
    !dec_valid && dec_ignored && $stable(opts) && $stable(dec_kind))
    else $error("unknown opcode acted");
  addr_a: assert property (
    cmd_valid && cmd_frame.opcode_high_byte[7] &&
    cmd_frame.opcode_high_byte[6:3] != device_addr |=> !dec_valid && dec_ignored)
    else $error("foreign address taken");
  busy_end_a: assert property (
    conv_busy && cnt == 28'h0000000 && !(take && starts_conv) |=> !conv_busy)
    else $error("busy overrun");
  poll_a: assert property (
    take && kind == cmd_pkg::K_POLL_CONVERSION && state == cmd_pkg::ST_BUSY &&
    cnt != 28'h0000000 |=> poll_valid && poll_busy)
    else $error("poll busy report");

  conv_c: cover property (take && starts_conv ##1 conv_busy [*3] ##1 take && reports);
  sys_c: cover property (take && kind == cmd_pkg::K_CONVERT_SYS);
  ign_c: cover property (dec_ignored ##1 dec_valid);
endmodule

// ===== logic/cmd_pkg.sv
package cmd_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int NS_PER_US = 1000;
  localparam int CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;

  localparam logic [10:0] OP_WRITE_SETUP_GROUP = 11'h001;
  localparam logic [10:0] OP_READ_SETUP_GROUP = 11'h002;
  localparam logic [10:0] OP_READ_CELL_GROUP_A = 11'h004;
  localparam logic [10:0] OP_READ_CELL_GROUP_B = 11'h006;
  localparam logic [10:0] OP_READ_CELL_GROUP_C = 11'h008;
  localparam logic [10:0] OP_READ_CELL_GROUP_D = 11'h00A;
  localparam logic [10:0] OP_READ_AUX_GROUP_A = 11'h00C;
  localparam logic [10:0] OP_READ_AUX_GROUP_B = 11'h00E;
  localparam logic [10:0] OP_READ_SYS_GROUP_A = 11'h010;
  localparam logic [10:0] OP_READ_SYS_GROUP_B = 11'h012;
  localparam logic [10:0] OP_CLEAR_CELL_GROUP = 11'h711;
  localparam logic [10:0] OP_CLEAR_AUX_GROUP = 11'h712;
  localparam logic [10:0] OP_CLEAR_SYS_GROUP = 11'h713;
  localparam logic [10:0] OP_POLL_CONVERSION = 11'h714;
  localparam logic [10:0] OP_CHECK_MUX = 11'h715;
  localparam logic [10:0] OP_WRITE_LINK_GROUP = 11'h721;
  localparam logic [10:0] OP_READ_LINK_GROUP = 11'h722;

  // opcode field positions
  localparam int F_GRP_HI = 10;
  localparam int F_GRP_LO = 9;
  localparam int F_RATE_HI = 8;
  localparam int F_RATE_LO = 7;
  localparam int F_PAT_HI = 6;
  localparam int F_PAT_LO = 5;
  localparam int F_DIR = 6;
  localparam int F_OW = 5;
  localparam int F_BAL = 4;
  localparam int F_B3 = 3;
  localparam int F_SEL_HI = 2;
  localparam int F_SEL_LO = 0;
  // first command byte: broadcast/address split
  localparam int F_ADDR_FLAG = 7;
  localparam int F_ADDR_HI = 6;
  localparam int F_ADDR_LO = 3;

  localparam logic [2:0] RATE_27K = 3'h0;
  localparam logic [2:0] RATE_14K = 3'h1;
  localparam logic [2:0] RATE_7K = 3'h2;
  localparam logic [2:0] RATE_3K = 3'h3;
  localparam logic [2:0] RATE_2K = 3'h4;
  localparam logic [2:0] RATE_26HZ = 3'h5;

  // conversion times in microseconds, fastest rate first
  localparam int T_ALL_US [6] = '{1100, 1300, 2300, 3000, 4400, 201000};
  localparam int T_PAIR_US [6] = '{201, 230, 405, 501, 754, 34000};
  localparam int T_SYS_ALL_US [6] = '{748, 865, 1600, 2000, 3000, 134000};

  localparam logic [5:0][27:0] ALL_CYC_DEF = {
    28'(T_ALL_US[5] * CYC_PER_US), 28'(T_ALL_US[4] * CYC_PER_US),
    28'(T_ALL_US[3] * CYC_PER_US), 28'(T_ALL_US[2] * CYC_PER_US),
    28'(T_ALL_US[1] * CYC_PER_US), 28'(T_ALL_US[0] * CYC_PER_US)};
  localparam logic [5:0][27:0] PAIR_CYC_DEF = {
    28'(T_PAIR_US[5] * CYC_PER_US), 28'(T_PAIR_US[4] * CYC_PER_US),
    28'(T_PAIR_US[3] * CYC_PER_US), 28'(T_PAIR_US[2] * CYC_PER_US),
    28'(T_PAIR_US[1] * CYC_PER_US), 28'(T_PAIR_US[0] * CYC_PER_US)};
  localparam logic [5:0][27:0] SYS_ALL_CYC_DEF = {
    28'(T_SYS_ALL_US[5] * CYC_PER_US), 28'(T_SYS_ALL_US[4] * CYC_PER_US),
    28'(T_SYS_ALL_US[3] * CYC_PER_US), 28'(T_SYS_ALL_US[2] * CYC_PER_US),
    28'(T_SYS_ALL_US[1] * CYC_PER_US), 28'(T_SYS_ALL_US[0] * CYC_PER_US)};

  localparam logic [15:0] ST1_FAST = 16'h9565;
  localparam logic [15:0] ST1_MID = 16'h9553;
  localparam logic [15:0] ST1_SLOW = 16'h9555;
  localparam logic [15:0] ST2_FAST = 16'h6A9A;
  localparam logic [15:0] ST2_MID = 16'h6AAC;
  localparam logic [15:0] ST2_SLOW = 16'h6AAA;

  typedef enum logic [4:0] {
    K_NONE = 5'h00, K_WRITE_SETUP_GROUP = 5'h01, K_READ_SETUP_GROUP = 5'h02,
    K_READ_CELL_GROUP_A = 5'h03, K_READ_CELL_GROUP_B = 5'h04, K_READ_CELL_GROUP_C = 5'h05,
    K_READ_CELL_GROUP_D = 5'h06, K_READ_AUX_GROUP_A = 5'h07, K_READ_AUX_GROUP_B = 5'h08,
    K_READ_SYS_GROUP_A = 5'h09, K_READ_SYS_GROUP_B = 5'h0A, K_CONVERT_CELLS = 5'h0B,
    K_CONVERT_OPEN_WIRE = 5'h0C, K_CHECK_CELLS_SELFTEST = 5'h0D, K_CONVERT_AUX = 5'h0E,
    K_CHECK_AUX_SELFTEST = 5'h0F, K_CONVERT_SYS = 5'h10, K_CHECK_SYS_SELFTEST = 5'h11,
    K_CONVERT_CELLS_AUX12 = 5'h12, K_CLEAR_CELL_GROUP = 5'h13, K_CLEAR_AUX_GROUP = 5'h14,
    K_CLEAR_SYS_GROUP = 5'h15, K_POLL_CONVERSION = 5'h16, K_CHECK_MUX = 5'h17,
    K_WRITE_LINK_GROUP = 5'h18, K_READ_LINK_GROUP = 5'h19
  } cmd_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } cmd_state_t;

  typedef struct packed {
    logic [7:0] opcode_high_byte;
    logic [7:0] low_byte;
  } cmd_frame_t;

  typedef struct packed {
    logic [2:0] adc_rate_sel;
    logic balance_allow;
    logic wire_test_current_dir;
    logic [11:0] cell_mask;
    logic [5:0] aux_mask;
    logic [2:0] sys_group_sel;
    logic [1:0] diag_pattern_sel;
    logic [15:0] diag_result;
    logic [27:0] conv_cycles;
  } cmd_opts_t;

  localparam cmd_opts_t OPTS_RST = '0;
  localparam logic [27:0] CNT_RST = 28'h0000000;
endpackage

// ===== verification/cmd_host.sv
`timescale 1ns/1ps
module cmd_host (
  input wire logic clk,
  output logic cmd_valid,
  output cmd_pkg::cmd_frame_t cmd_frame,
  output logic alt_rate_opt
);
  initial begin
    cmd_valid = 1'b0;
    cmd_frame = 16'hA5A5;
    alt_rate_opt = 1'b0;
  end
  // between requests the frame shows the inverse of the last one, so a
  // decoder that samples it without cmd_valid cannot look right by luck
  task automatic send(input cmd_pkg::cmd_frame_t f, input logic alt);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_frame = f;
    alt_rate_opt = alt;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_frame = ~f;
  endtask
endmodule

// ===== verification/cmd_decoder_tb.sv
`timescale 1ns/1ps
module cmd_decoder_tb;
  // short conversion lengths, distinct per rate so a wrong index shows
  localparam logic [5:0][27:0] ALL_C = {28'd25, 28'd24, 28'd23, 28'd22, 28'd21, 28'd20};
  localparam logic [5:0][27:0] PAIR_C = {28'd13, 28'd12, 28'd11, 28'd10, 28'd9, 28'd8};
  localparam logic [5:0][27:0] SYS_C = {28'd17, 28'd16, 28'd15, 28'd14, 28'd13, 28'd12};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] device_addr = 4'h5;
  logic cmd_valid;
  logic alt_rate_opt;
  cmd_pkg::cmd_frame_t cmd_frame;
  cmd_pkg::cmd_kind_t dec_kind;
  cmd_pkg::cmd_opts_t opts;
  logic dec_valid, dec_ignored, conv_busy, poll_valid, poll_busy;
  int num_errors = 0;
  int checks = 0;
  always #4 clk = ~clk;
  cmd_host u_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_frame(cmd_frame),
    .alt_rate_opt(alt_rate_opt));
  cmd_decoder #(.ALL_CYC(ALL_C), .PAIR_CYC(PAIR_C), .SYS_ALL_CYC(SYS_C)) dut (
    .clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_frame(cmd_frame),
    .alt_rate_opt(alt_rate_opt), .device_addr(device_addr), .dec_kind(dec_kind),
    .dec_valid(dec_valid), .dec_ignored(dec_ignored), .opts(opts), .conv_busy(conv_busy),
    .poll_valid(poll_valid), .poll_busy(poll_busy));
  // wide enough for the whole option record in one compare
  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cmd(input logic [4:0] pre, input logic [10:0] op, input logic alt);
    u_host.send({pre, op}, alt);
  endtask
  // broadcast that must be taken as kind k; outputs are read one cycle on
  task automatic acc(input logic [10:0] op, input logic alt, input cmd_pkg::cmd_kind_t k);
    cmd(5'h00, op, alt);
    chk(dec_valid, 1'b1);
    chk(dec_kind, k);
  endtask
  task automatic ign(input logic [4:0] pre, input logic [10:0] op);
    cmd(pre, op, 1'b0);
    chk({dec_ignored, dec_valid}, 2'b10);
  endtask
  initial begin
    logic [10:0] op;
    int r;
    int n;
    repeat (20) @(negedge clk);
    chk({dec_kind, dec_valid, conv_busy, poll_valid, opts}, '0);
    reset_n = 1'b1;
    for (int i = 1; i <= 25; i++) begin
      if (i <= 10) op = (i == 1) ? 11'h001 : 11'(2 * (i - 1));
      else if (i >= 19 && i <= 23) op = 11'(11'h711 + i - 19);
      else if (i >= 24) op = 11'(11'h721 + i - 24);
      else continue;
      acc(op, 1'b0, cmd_pkg::cmd_kind_t'(i));
    end
    for (int a = 0; a < 2; a++) begin
      for (int m = 1; m < 4; m++) begin
        r = a ? (m == 1 ? 1 : m == 2 ? 3 : 4) : (m == 1 ? 0 : m == 2 ? 2 : 5);
        acc(11'h260 | 11'(m << 7), a[0], cmd_pkg::K_CONVERT_CELLS);
        chk(opts.adc_rate_sel, r);
        chk({opts.cell_mask, opts.balance_allow}, {12'hFFF, 1'b0});
        chk(opts.conv_cycles, ALL_C[r]);
      end
    end
    acc(11'h2E1, 1'b0, cmd_pkg::K_CONVERT_CELLS);
    chk({opts.cell_mask, opts.conv_cycles}, {12'h041, PAIR_C[0]});
    n = 0;
    while (conv_busy === 1'b1 && n < 100) begin
      n++;
      @(negedge clk);
    end
    chk(n, PAIR_C[0]);
    acc(11'h373, 1'b0, cmd_pkg::K_CONVERT_CELLS);
    chk({opts.cell_mask, opts.balance_allow}, {12'h104, 1'b1});
    chk(opts.conv_cycles, PAIR_C[2]);
    n = 0;
    while (conv_busy === 1'b1 && n < 100) begin
      n++;
      @(negedge clk);
    end
    chk(n, PAIR_C[2]);
    acc(11'h714, 1'b0, cmd_pkg::K_POLL_CONVERSION);
    chk({poll_valid, poll_busy, opts.cell_mask}, {2'b10, 12'h104});
    acc(11'h2E0, 1'b0, cmd_pkg::K_CONVERT_CELLS);
    acc(11'h714, 1'b0, cmd_pkg::K_POLL_CONVERSION);
    chk({poll_valid, poll_busy}, 2'b11);
    acc(11'h715, 1'b0, cmd_pkg::K_CHECK_MUX);
    chk({poll_valid, poll_busy, opts.conv_cycles}, {2'b11, PAIR_C[0]});
    for (int p = 0; p < 2; p++) begin
      acc(11'h2A9 | 11'(p << 6), 1'b0, cmd_pkg::K_CONVERT_OPEN_WIRE);
      chk({opts.wire_test_current_dir, opts.cell_mask}, {p[0], 12'h041});
    end
    acc(11'h2A7, 1'b0, cmd_pkg::K_CHECK_CELLS_SELFTEST);
    chk(opts.diag_result, 16'h9565);
    acc(11'h3C7, 1'b0, cmd_pkg::K_CHECK_CELLS_SELFTEST);
    chk({opts.diag_result, opts.adc_rate_sel}, {16'h6AAA, 3'h5});
    acc(11'h4C7, 1'b0, cmd_pkg::K_CHECK_AUX_SELFTEST);
    chk(opts.diag_result, 16'h6A9A);
    acc(11'h4AF, 1'b0, cmd_pkg::K_CHECK_SYS_SELFTEST);
    chk({opts.diag_pattern_sel, opts.diag_result}, {2'h1, 16'h9565});
    acc(11'h4E0, 1'b0, cmd_pkg::K_CONVERT_AUX);
    chk({opts.aux_mask, opts.cell_mask}, {6'h3F, 12'h000});
    acc(11'h4E6, 1'b0, cmd_pkg::K_CONVERT_AUX);
    chk(opts.aux_mask, 6'h20);
    acc(11'h4EA, 1'b0, cmd_pkg::K_CONVERT_SYS);
    chk(opts.sys_group_sel, 3'h2);
    acc(11'h4E8, 1'b0, cmd_pkg::K_CONVERT_SYS);
    chk(opts.conv_cycles, SYS_C[0]);
    acc(11'h4ED, 1'b0, cmd_pkg::K_CONVERT_AUX);
    chk(opts.aux_mask, 6'h10);
    acc(11'h4FF, 1'b0, cmd_pkg::K_CONVERT_CELLS_AUX12);
    chk({opts.cell_mask, opts.aux_mask, opts.balance_allow}, {12'hFFF, 6'h03, 1'b1});
    ign(5'h00, 11'h7FF);
    chk({dec_kind, opts.aux_mask}, {cmd_pkg::K_CONVERT_CELLS_AUX12, 6'h03});
    cmd(5'h15, 11'h002, 1'b0);
    chk({dec_valid, dec_kind}, {1'b1, cmd_pkg::K_READ_SETUP_GROUP});
    ign(5'h16, 11'h004);
    ign(5'h01, 11'h004);
    chk(dec_kind, cmd_pkg::K_READ_SETUP_GROUP);
    wrap_up();
  end
  // generous bound; the sequence needs well under a thousand cycles
  initial begin
    #200000;
    num_errors++;
    wrap_up();
  end
endmodule
